/* File: logic/cis_sequencer.sv */
`include "cis_cfg.svh"
`default_nettype none

module cis_sequencer
    import cis_pkg::*;
#(
    parameter int          N_SRC      = 8,
    parameter logic [N_SRC-1:0] LEVEL_MASK = '0,
    parameter logic [15:0] BOOT_BASE  = `CIS_BOOT_BASE
) (
    input  wire  logic             I_CLK,
    input  wire  logic             I_RST_B,
    input  wire  logic             I_PSEL,
    input  wire  logic             I_PENABLE,
    input  wire  logic             I_PWRITE,
    input  wire  logic [7:0]       I_PADDR,
    input  wire  logic [31:0]      I_PWDATA,
    output var   logic [31:0]      O_PRDATA,
    output var   logic             O_PREADY,
    output var   logic             O_PSLVERR,
    input  wire  logic [N_SRC-1:0] I_SRC_EVENT,
    input  wire  logic [N_SRC-1:0] I_SRC_LEVEL,
    input  wire  logic             I_INSTR_DONE,
    input  wire  logic             I_SEI,
    input  wire  logic             I_CLI,
    input  wire  logic             I_RETURN_FROM_IRQ_INSTR,
    input  wire  logic             I_SLEEPING,
    input  wire  logic [15:0]      I_PC,
    input  wire  logic             I_RST_VEC_BOOT,
    input  wire  logic             I_APP_LOCK,
    input  wire  logic             I_BOOT_LOCK,
    input  wire  logic [7:0]       I_STK_RDATA,
    output var   cis_stk_s         O_STK,
    output var   cis_jump_s        O_JUMP,
    output var   logic             O_STALL,
    output var   logic             O_GIE,
    output var   logic [15:0]      O_SP
);

    localparam int IW = $clog2(N_SRC + 1);

    cis_state_e       state_reg;
    cis_state_e       state_next;
    logic [N_SRC-1:0] flag_reg;
    logic [N_SRC-1:0] enable_reg;
    logic             vbs_reg;
    logic             gie_reg;
    logic             shadow_reg;
    logic [15:0]      sp_reg;
    logic [15:0]      pc_save_reg;
    logic [7:0]       pc_hi_reg;
    logic [IW-1:0]    idx_reg;
    logic [2:0]       wake_cnt_reg;
    logic [N_SRC-1:0] req;
    logic [N_SRC-1:0] hw_clr;
    logic [IW-1:0]    win_idx;
    logic             win_any;
    logic             pc_in_boot;
    logic             locked;
    logic             take;
    logic             ret_go;
    logic             apb_wr;
    logic             apb_setup;
    logic [15:0]      vec_base;
    logic [31:0]      rd_mux;
    logic             rd_hit;

    // ========================================================
    // apb access decode
    assign apb_setup = I_PSEL & ~I_PENABLE;
    assign apb_wr    = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;

    always_comb begin
        rd_mux = 32'h0;
        rd_hit = 1'b1;
        case (I_PADDR)
            `CIS_ADDR_CTRL: begin
                rd_mux[`CIS_CTRL_VBS] = vbs_reg;
                rd_mux[`CIS_CTRL_GIE] = gie_reg;
            end
            `CIS_ADDR_ENABLE: rd_mux[N_SRC-1:0] = enable_reg;
            `CIS_ADDR_FLAG:   rd_mux[N_SRC-1:0] = flag_reg;
            `CIS_ADDR_SP:     rd_mux[15:0] = sp_reg;
            `CIS_ADDR_STATUS: begin
                rd_mux[3:0]    = state_reg;
                rd_mux[4]      = shadow_reg;
                rd_mux[5]      = win_any;
                rd_mux[8+:IW]  = win_idx;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // zero wait states: ready in the first access cycle
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= 32'h0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= apb_setup;
            O_PRDATA  <= apb_setup ? rd_mux : 32'h0;
            O_PSLVERR <= apb_setup & ~rd_hit;
        end
    end

    // ========================================================
    // request qualification
    // own enable gating
    assign req = ((LEVEL_MASK & I_SRC_LEVEL) | (~LEVEL_MASK & flag_reg))
               & enable_reg;

    always_comb begin
        win_idx = '0;
        win_any = 1'b0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                win_idx = IW'(i + 1);
                win_any = 1'b1;
            end
        end
    end

    assign pc_in_boot = (I_PC >= BOOT_BASE);
    assign locked = (I_APP_LOCK & ~pc_in_boot & vbs_reg)
                  | (I_BOOT_LOCK & pc_in_boot & ~vbs_reg);

    // accept only at instruction boundary or in sleep
    // disable instruction blocks the same cycle
    // shadow holds off after return and enable
    assign ret_go = (state_reg == CIS_IDLE) & I_RETURN_FROM_IRQ_INSTR;
    assign take   = (state_reg == CIS_IDLE) & ~I_RETURN_FROM_IRQ_INSTR & win_any
                  & gie_reg & ~shadow_reg & ~I_CLI & ~locked
                  & (I_INSTR_DONE | I_SLEEPING);

    assign vec_base = vbs_reg ? BOOT_BASE : 16'h0000;

    // ========================================================
    // sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CIS_RST_VEC: state_next = CIS_IDLE;
            CIS_IDLE: begin
                if (ret_go) begin
                    state_next = CIS_POP_HI;
                end else if (take) begin
                    state_next = I_SLEEPING ? CIS_WAKE : CIS_PUSH_LO;
                end
            end
            CIS_WAKE: begin
                if (wake_cnt_reg == 3'(`CIS_WAKE_CYCLES - 1)) begin
                    state_next = CIS_PUSH_LO;
                end
            end
            CIS_PUSH_LO:  state_next = CIS_PUSH_HI;
            CIS_PUSH_HI:  state_next = CIS_ENT_WAIT;
            CIS_ENT_WAIT: state_next = CIS_VECTOR;
            CIS_VECTOR:   state_next = CIS_IDLE;
            CIS_POP_HI:   state_next = CIS_POP_LO;
            CIS_POP_LO:   state_next = CIS_POP_CAP;
            CIS_POP_CAP:  state_next = CIS_RET_DONE;
            CIS_RET_DONE: state_next = CIS_IDLE;
            default:      state_next = CIS_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_reg <= CIS_RST_VEC;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            wake_cnt_reg <= 3'h0;
        end else if (state_reg == CIS_WAKE) begin
            wake_cnt_reg <= wake_cnt_reg + 3'h1;
        end else begin
            wake_cnt_reg <= 3'h0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            idx_reg     <= '0;
            pc_save_reg <= 16'h0;
        end else if (take) begin
            idx_reg     <= win_idx;
            pc_save_reg <= I_PC;
        end
    end

    // ========================================================
    // flags, one per source
    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : g_flag
            assign hw_clr[g] = take & (win_idx == IW'(g + 1));
            // held while global enable is clear
            always_ff @(posedge I_CLK or negedge I_RST_B) begin
                if (!I_RST_B) begin
                    flag_reg[g] <= 1'b0;
                end else if (LEVEL_MASK[g]) begin
                    flag_reg[g] <= 1'b0;
                end else if (I_SRC_EVENT[g]) begin
                    flag_reg[g] <= 1'b1;
                end else if (hw_clr[g] | (apb_wr & I_PWDATA[g]
                             & (I_PADDR == `CIS_ADDR_FLAG))) begin
                    flag_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ========================================================
    // control registers
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            enable_reg <= '0;
            vbs_reg    <= 1'b0;
        end else if (apb_wr && I_PADDR == `CIS_ADDR_ENABLE) begin
            enable_reg <= I_PWDATA[N_SRC-1:0];
        end else if (apb_wr && I_PADDR == `CIS_ADDR_CTRL) begin
            vbs_reg <= I_PWDATA[`CIS_CTRL_VBS];
        end
    end

    // global enable
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            gie_reg <= 1'b0;
        end else if (take) begin
            gie_reg <= 1'b0;
        end else if (state_reg == CIS_RET_DONE) begin
            gie_reg <= 1'b1;
        end else if (I_CLI) begin
            gie_reg <= 1'b0;
        end else if (I_SEI) begin
            gie_reg <= 1'b1;
        end else if (apb_wr && I_PADDR == `CIS_ADDR_CTRL) begin
            gie_reg <= I_PWDATA[`CIS_CTRL_GIE];
        end
    end

    // one-instruction hold-off
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            shadow_reg <= 1'b0;
        end else if (state_reg == CIS_RET_DONE) begin
            shadow_reg <= 1'b1;
        end else if (I_SEI) begin
            shadow_reg <= 1'b1;
        end else if (I_INSTR_DONE) begin
            shadow_reg <= 1'b0;
        end
    end

    // stack pointer
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sp_reg <= `CIS_SP_RESET;
        end else if (state_reg == CIS_PUSH_HI) begin
            sp_reg <= sp_reg - `CIS_SP_STEP;
        end else if (state_reg == CIS_RET_DONE) begin
            sp_reg <= sp_reg + `CIS_SP_STEP;
        end else if (apb_wr && I_PADDR == `CIS_ADDR_SP) begin
            sp_reg <= I_PWDATA[15:0];
        end
    end

    // ========================================================
    // stack port, outputs follow the state being entered
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_STK     <= '0;
            pc_hi_reg <= 8'h0;
        end else begin
            O_STK <= '0;
            case (state_next)
                CIS_PUSH_LO: begin
                    O_STK.we    <= 1'b1;
                    O_STK.addr  <= sp_reg;
                    O_STK.wdata <= take ? I_PC[7:0] : pc_save_reg[7:0];
                end
                CIS_PUSH_HI: begin
                    O_STK.we    <= 1'b1;
                    O_STK.addr  <= sp_reg - 16'h0001;
                    O_STK.wdata <= pc_save_reg[15:8];
                end
                CIS_POP_HI: begin
                    O_STK.re   <= 1'b1;
                    O_STK.addr <= sp_reg + 16'h0001;
                end
                CIS_POP_LO: begin
                    O_STK.re   <= 1'b1;
                    O_STK.addr <= sp_reg + `CIS_SP_STEP;
                end
                default: O_STK <= '0;
            endcase
            if (state_reg == CIS_POP_LO) begin
                pc_hi_reg <= I_STK_RDATA;
            end
        end
    end

    // ========================================================
    // jump to fetch unit
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_JUMP <= '0;
        end else begin
            O_JUMP <= '0;
            if (state_reg == CIS_RST_VEC) begin
                O_JUMP.vec_valid <= 1'b1;
                O_JUMP.addr <= I_RST_VEC_BOOT ? BOOT_BASE : 16'h0000;
            end else if (state_next == CIS_VECTOR) begin
                O_JUMP.vec_valid <= 1'b1;
                O_JUMP.addr <= vec_base + 16'(idx_reg);
            end else if (state_next == CIS_RET_DONE) begin
                O_JUMP.ret_valid <= 1'b1;
                O_JUMP.addr <= {pc_hi_reg, I_STK_RDATA};
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_STALL <= 1'b1;
            O_GIE   <= 1'b0;
            O_SP    <= `CIS_SP_RESET;
        end else begin
            O_STALL <= (state_next != CIS_IDLE);
            O_GIE   <= gie_reg;
            O_SP    <= sp_reg;
        end
    end

endmodule // cis_sequencer

`default_nettype wire

/* File: logic/cis_cfg.svh */
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH

// ============================================================
// register byte addresses
`define CIS_ADDR_CTRL     8'h00
`define CIS_ADDR_ENABLE   8'h04
`define CIS_ADDR_FLAG     8'h08
`define CIS_ADDR_SP       8'h0c
`define CIS_ADDR_STATUS   8'h10

// ============================================================
// control field positions
`define CIS_CTRL_VBS      0
`define CIS_CTRL_GIE      1

// ============================================================
// reset values
`define CIS_CTRL_RESET    2'h0
`define CIS_SP_RESET      16'h00ff
`define CIS_BOOT_BASE     16'h3800

// ============================================================
// timing counts in clock cycles, and the stack pointer step
`define CIS_ENTRY_CYCLES  4
`define CIS_WAKE_CYCLES   4
`define CIS_RET_CYCLES    4
`define CIS_SP_STEP       16'h0002

`endif

/* File: logic/cis_pkg.sv */
`default_nettype none

package cis_pkg;

    // ========================================================
    // sequencer states, gray along entry and return paths
    typedef enum logic [3:0] {
        CIS_RST_VEC  = 4'h4,
        CIS_IDLE     = 4'h0,
        CIS_WAKE     = 4'h1,
        CIS_PUSH_LO  = 4'h3,
        CIS_PUSH_HI  = 4'h2,
        CIS_ENT_WAIT = 4'h6,
        CIS_VECTOR   = 4'h7,
        CIS_POP_HI   = 4'h8,
        CIS_POP_LO   = 4'h9,
        CIS_POP_CAP  = 4'hb,
        CIS_RET_DONE = 4'ha
    } cis_state_e;

    // ========================================================
    // stack memory access
    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cis_stk_s;

    // ========================================================
    // program flow redirect towards the fetch unit
    typedef struct packed {
        logic        vec_valid;
        logic        ret_valid;
        logic [15:0] addr;
    } cis_jump_s;

endpackage

`default_nettype wire

/* File: tb/cis_stack_model.sv */
`default_nettype none

module cis_stack_model
    import cis_pkg::*;
(
    input  wire logic       i_clk,
    input  wire cis_stk_s   i_stk,
    output var  logic [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem_reg [0:255];
    logic [7:0] last_reg = 8'h00;
    logic       rd_reg = 1'b0;

    // ========================================================
    // stack memory, answer one cycle after the read strobe
    // only the return address is stacked
    always_ff @(posedge i_clk) begin
        if (i_stk.we)
            mem_reg[i_stk.addr[7:0]] <= i_stk.wdata;
        rd_reg <= i_stk.re;
        if (i_stk.re)
            last_reg <= mem_reg[i_stk.addr[7:0]];
    end

    // released bus shows the inverse of the last byte
    assign o_rdata = rd_reg ? last_reg : ~last_reg;
endmodule // cis_stack_model

`default_nettype wire

/* File: tb/cis_seq_sva.sv */
`default_nettype none

module cis_seq_sva
    import cis_pkg::*;
#(
    parameter logic [15:0] BOOT_BASE = 16'h3800
) (
    input wire logic        I_CLK,
    input wire logic        I_RST_B,
    input wire logic        I_INSTR_DONE,
    input wire logic        I_SEI,
    input wire logic        I_CLI,
    input wire logic        I_RETURN_FROM_IRQ_INSTR,
    input wire logic        I_SLEEPING,
    input wire logic        I_RST_VEC_BOOT,
    input wire cis_stk_s    O_STK,
    input wire cis_jump_s   O_JUMP,
    input wire logic        O_STALL,
    input wire logic        O_GIE,
    input wire logic [15:0] O_SP
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);

    // ========================================================
    // entry
    a_reset_vec: assert property (
        $rose(I_RST_B) |=> O_JUMP.vec_valid &&
        O_JUMP.addr == (I_RST_VEC_BOOT ? BOOT_BASE : 16'h0000))
        else $error("reset vector wrong");
    a_entry_len: assert property (
        $rose(O_STK.we) |-> ##3 O_JUMP.vec_valid)
        else $error("entry length wrong");
    a_push_sp: assert property (
        $rose(O_STK.we) |=> O_STK.we &&
        O_STK.addr == $past(O_STK.addr) - 16'h0001 ##2
        O_SP == $past(O_STK.addr, 3) - 16'h0002)
        else $error("push order or stack step wrong");
    a_entry_gie: assert property (
        $rose(O_STK.we) |=> !O_GIE)
        else $error("global enable kept on entry");
    a_take_boundary: assert property (
        !I_INSTR_DONE && !I_SLEEPING && !I_RETURN_FROM_IRQ_INSTR && !O_STALL |=> !O_STALL)
        else $error("entry inside an instruction");
    a_cli_blocks: assert property (
        I_CLI && !I_RETURN_FROM_IRQ_INSTR && !O_STALL |=> !O_STALL)
        else $error("entry after disable");
    a_sei_holdoff: assert property (
        (I_SEI && !O_STALL ##1 !O_STALL && !I_RETURN_FROM_IRQ_INSTR) |=> !O_STALL)
        else $error("entry right after enable");

    // ========================================================
    // return
    a_ret_len: assert property (
        $rose(O_STK.re) |-> ##3 O_JUMP.ret_valid)
        else $error("return length wrong");
    a_ret_gie_sp: assert property (
        O_JUMP.ret_valid |-> ##2
        O_GIE && O_SP == $past(O_STK.addr, 5) + 16'h0001)
        else $error("return enable or stack wrong");
    a_ret_holdoff: assert property (
        O_JUMP.ret_valid ##1 !I_RETURN_FROM_IRQ_INSTR |=> !O_STALL)
        else $error("entry right after return");

    c_sleep_vec: cover property (O_JUMP.vec_valid && I_SLEEPING);
    c_ret: cover property (O_JUMP.ret_valid);
    c_cli: cover property (I_CLI && !O_STALL);
endmodule // cis_seq_sva

bind cis_sequencer cis_seq_sva #(.BOOT_BASE(BOOT_BASE)) sva_u (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_INSTR_DONE(I_INSTR_DONE),
    .I_SEI(I_SEI), .I_CLI(I_CLI), .I_RETURN_FROM_IRQ_INSTR(I_RETURN_FROM_IRQ_INSTR),
    .I_SLEEPING(I_SLEEPING), .I_RST_VEC_BOOT(I_RST_VEC_BOOT),
    .O_STK(O_STK), .O_JUMP(O_JUMP), .O_STALL(O_STALL), .O_GIE(O_GIE),
    .O_SP(O_SP));

`default_nettype wire

/* File: tb/tb.sv */
`include "cis_cfg.svh"
`default_nettype none

module tb
    import cis_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] BB = `CIS_BOOT_BASE;
    logic        I_CLK = 1'b0, I_RST_B = 1'b0, I_PSEL = 1'b0;
    logic        I_PENABLE = 1'b0, I_PWRITE = 1'b0, I_SLEEPING = 1'b0;
    logic        I_INSTR_DONE = 1'b0, I_SEI = 1'b0, I_CLI = 1'b0;
    logic        I_RETURN_FROM_IRQ_INSTR = 1'b0, I_RST_VEC_BOOT = 1'b0;
    logic        I_APP_LOCK = 1'b0, I_BOOT_LOCK = 1'b0;
    logic [7:0]  I_PADDR = 8'h00, I_SRC_EVENT = 8'h00, I_SRC_LEVEL = 8'h00;
    logic [31:0] I_PWDATA = 32'h0, O_PRDATA, rd;
    logic        O_PREADY, O_PSLVERR, O_STALL, O_GIE, slv;
    logic [15:0] I_PC = 16'h0000, O_SP;
    logic [7:0]  stk_rdata;
    cis_stk_s    O_STK;
    cis_jump_s   O_JUMP;
    int          mismatches = 0, cmp_count = 0, cyc = 0, s;

    cis_sequencer #(.LEVEL_MASK(8'h80), .BOOT_BASE(BB)) dut_u (
        .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL),
        .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
        .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
        .O_PSLVERR(O_PSLVERR), .I_SRC_EVENT(I_SRC_EVENT),
        .I_SRC_LEVEL(I_SRC_LEVEL), .I_INSTR_DONE(I_INSTR_DONE),
        .I_SEI(I_SEI), .I_CLI(I_CLI), .I_RETURN_FROM_IRQ_INSTR(I_RETURN_FROM_IRQ_INSTR),
        .I_SLEEPING(I_SLEEPING), .I_PC(I_PC),
        .I_RST_VEC_BOOT(I_RST_VEC_BOOT), .I_APP_LOCK(I_APP_LOCK),
        .I_BOOT_LOCK(I_BOOT_LOCK), .I_STK_RDATA(stk_rdata), .O_STK(O_STK),
        .O_JUMP(O_JUMP), .O_STALL(O_STALL), .O_GIE(O_GIE), .O_SP(O_SP));

    cis_stack_model stk_u (.i_clk(I_CLK), .i_stk(O_STK), .o_rdata(stk_rdata));

    always #4 I_CLK = ~I_CLK;
    always @(posedge I_CLK) I_INSTR_DONE <= 1'($urandom % 2);

    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end

    function automatic logic [15:0] vaddr(input int v, input int i);
        return ((v != 0) ? BB : 16'h0000) + 16'(i + 1);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input int w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge I_CLK);
        I_PSEL <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE <= (w != 0);
        I_PADDR <= a;
        I_PWDATA <= d;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        // sample ready and read data at the completing edge
        do @(posedge I_CLK); while (O_PREADY !== 1'b1);
        rd = O_PRDATA;
        slv = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask

    task automatic ev(input logic [7:0] m);
        @(posedge I_CLK);
        I_SRC_EVENT <= m;
        @(posedge I_CLK);
        I_SRC_EVENT <= 8'h00;
    endtask

    // wait for a vector, counting the stalled cycles up to it
    task automatic serve(input logic [15:0] a, input int n);
        int c;
        c = 0;
        do begin
            @(posedge I_CLK);
            #1;
            c += int'(O_STALL === 1'b1);
        end while (O_JUMP.vec_valid !== 1'b1);
        chk(32'(O_JUMP.addr), 32'(a));
        chk(32'(c), 32'(n));
    endtask

    task automatic retn();
        @(posedge I_CLK);
        I_RETURN_FROM_IRQ_INSTR <= 1'b1;
        @(posedge I_CLK);
        I_RETURN_FROM_IRQ_INSTR <= 1'b0;
        #1;
        while (O_JUMP.ret_valid !== 1'b1) begin
            @(posedge I_CLK);
            #1;
        end
        chk(32'(O_JUMP.addr), 32'(I_PC));
    endtask

    task automatic rst();
        @(posedge I_CLK);
        I_RST_B <= 1'b0;
        repeat (3) @(posedge I_CLK);
        I_RST_B <= 1'b1;
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        s = $urandom(28612);
        rst();
        serve(16'h0000, 0);
        apb(0, `CIS_ADDR_CTRL, 0);
        chk(rd, 32'h0);
        apb(0, `CIS_ADDR_SP, 0);
        chk(rd, 32'(`CIS_SP_RESET));
        apb(0, 8'h14, 0);
        chk(32'(slv), 32'h1);
        s = $urandom % 6;
        I_PC <= 16'($urandom);
        ev(8'h03 << s);
        apb(0, `CIS_ADDR_FLAG, 0);
        chk(rd, 32'h3 << s);
        apb(1, `CIS_ADDR_FLAG, 0);
        apb(0, `CIS_ADDR_FLAG, 0);
        chk(rd, 32'h3 << s);
        apb(1, `CIS_ADDR_FLAG, 32'h1 << s);
        apb(0, `CIS_ADDR_FLAG, 0);
        chk(rd, 32'h2 << s);
        ev(8'h01 << s);
        apb(1, `CIS_ADDR_ENABLE, 32'hff);
        apb(1, `CIS_ADDR_CTRL, 32'h2);
        serve(vaddr(0, s), 4);
        apb(0, `CIS_ADDR_FLAG, 0);
        chk(rd, 32'h2 << s);
        apb(0, `CIS_ADDR_SP, 0);
        chk(rd, 32'h00fd);
        retn();
        serve(vaddr(0, s + 1), 4);
        retn();
        apb(1, `CIS_ADDR_ENABLE, 32'h0);
        ev(8'h01);
        apb(1, `CIS_ADDR_CTRL, 32'h3);
        I_SLEEPING <= 1'b1;
        apb(1, `CIS_ADDR_ENABLE, 32'hff);
        serve(vaddr(1, 0), 8);
        I_SLEEPING <= 1'b0;
        retn();
        apb(1, `CIS_ADDR_ENABLE, 32'h7f);
        @(posedge I_CLK);
        I_SRC_LEVEL <= 8'h80;
        repeat (3) @(posedge I_CLK);
        I_SRC_LEVEL <= 8'h00;
        apb(1, `CIS_ADDR_ENABLE, 32'hff);
        repeat (10) @(posedge I_CLK);
        #1;
        chk(32'(O_STALL), 32'h0);
        chk(32'(O_SP), 32'(`CIS_SP_RESET));
        @(posedge I_CLK);
        I_SRC_LEVEL <= 8'h80;
        serve(vaddr(1, 7), 4);
        I_SRC_LEVEL <= 8'h00;
        retn();
        // let the hold-off after return lapse, then make a request
        // that would be taken in the very cycle of the disable
        repeat (8) @(posedge I_CLK);
        I_CLI <= 1'b1;
        I_SLEEPING <= 1'b1;
        I_SRC_LEVEL <= 8'h80;
        I_SRC_EVENT <= 8'h04;
        @(posedge I_CLK);
        I_CLI <= 1'b0;
        I_SLEEPING <= 1'b0;
        I_SRC_LEVEL <= 8'h00;
        I_SRC_EVENT <= 8'h00;
        repeat (8) @(posedge I_CLK);
        #1;
        chk(32'(O_STALL), 32'h0);
        chk(32'(O_SP), 32'(`CIS_SP_RESET));
        apb(0, `CIS_ADDR_FLAG, 0);
        chk(rd, 32'h4);
        @(posedge I_CLK);
        I_SEI <= 1'b1;
        @(posedge I_CLK);
        I_SEI <= 1'b0;
        serve(vaddr(1, 2), 4);
        retn();
        // application lock with vectors in boot and pc below boot
        I_APP_LOCK <= 1'b1;
        I_PC <= 16'h0100;
        ev(8'h02);
        repeat (8) @(posedge I_CLK);
        #1;
        chk(32'(O_SP), 32'(`CIS_SP_RESET));
        apb(0, `CIS_ADDR_FLAG, 0);
        chk(rd, 32'h2);
        I_APP_LOCK <= 1'b0;
        I_BOOT_LOCK <= 1'b1;
        serve(vaddr(1, 1), 4);
        retn();
        I_BOOT_LOCK <= 1'b0;
        I_RST_VEC_BOOT <= 1'b1;
        rst();
        serve(BB, 0);
        summarize();
    end
endmodule // tb

`default_nettype wire
